// ===== src/pif_regs.svh
// Register offsets, field positions, masks and reset values for the flag block.
`ifndef PIF_REGS_SVH
`define PIF_REGS_SVH
// ***************************************************************
// Register offsets
// ***************************************************************
`define PIF_ADDR_W 12
`define PIF_OFS_REQ0 12'h70c
`define PIF_OFS_REQ1 12'h70d
`define PIF_OFS_REQ2 12'h70e
`define PIF_OFS_EN0 12'h716
`define PIF_OFS_EN1 12'h717
`define PIF_OFS_EN2 12'h718
`define PIF_OFS_GCTL 12'h00b
// ***************************************************************
// Field positions
// ***************************************************************
`define PIF_B0_TMR0 5
`define PIF_B0_IOC 4
`define PIF_B0_EXT 0
`define PIF_B1_RX 4
`define PIF_B1_TX 3
`define PIF_B2_GATE 5
`define PIF_GC_GLOBAL 7
`define PIF_GC_PERIPH 6
`define PIF_GC_EDGE 0
// ***************************************************************
// Masks and reset values
// ***************************************************************
`define PIF_MASK0 8'h31
`define PIF_MASK1 8'hff
`define PIF_MASK2 8'he0
`define PIF_SWMASK0 8'h21
`define PIF_SWMASK1 8'he7
`define PIF_SWMASK2 8'he0
`define PIF_MASKGC 8'hc1
`define PIF_RST_REQ 8'h00
`define PIF_RST_EN 8'h00
`define PIF_RST_GCTL 8'h01
`endif

// ===== src/pif_pkg.sv
// Types shared by the flag block.
package pif_pkg;
   // Capture-compare unit operating modes.
   typedef enum logic [1:0] {
      pif_capcomp_capture,
      pif_capcomp_compare,
      pif_capcomp_pwm
   } pif_capcomp_mode_type;
endpackage : pif_pkg

// ===== src/pif_sync.sv
// Two-flop synchroniser for asynchronous pin inputs.
`timescale 1ns/1ps
module pif_sync #(
   parameter int WIDTH = 1
) (
   input wire logic mclk, // System clock.
   input wire logic sys_rst, // Synchronous reset.
   input wire logic [WIDTH-1:0] din, // Asynchronous input.
   output logic [WIDTH-1:0] dout // Synchronised output.
);
   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed {
      logic [WIDTH-1:0] s1; // First stage, read only by the second.
      logic [WIDTH-1:0] s2; // Second stage.
   } pif_sync_state_type;
   pif_sync_state_type st_q; // Registered state.
   pif_sync_state_type st_d; // Next state.

   // Shift the input through both stages.
   always_comb begin
      st_d = st_q;
      st_d.s1 = din;
      st_d.s2 = st_q.s1;
   end

   // Register the state; reset clears both stages.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign dout = st_q.s2;
endmodule : pif_sync

// ===== src/pif_edge.sv
// Selectable rising or falling edge detector on a synchronised level.
`timescale 1ns/1ps
module pif_edge (
   input wire logic mclk, // System clock.
   input wire logic sys_rst, // Synchronous reset.
   input wire logic level, // Synchronised level.
   input wire logic rising, // One selects rising edge, zero falling.
   output logic hit // One-cycle pulse on the chosen edge.
);
   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed {
      logic prev; // Level one cycle ago.
      logic seen; // Set once the first sample is taken.
   } pif_edge_state_type;
   pif_edge_state_type st_q; // Registered state.
   pif_edge_state_type st_d; // Next state.

   // Track the previous level; no edge is reported before a real sample.
   always_comb begin
      st_d = st_q;
      st_d.prev = level;
      st_d.seen = 1'b1;
   end

   // Register the state.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // Compare the new level with the old one in the chosen direction.
   assign hit = st_q.seen & (rising ? (level & ~st_q.prev) : (~level & st_q.prev));
endmodule : pif_edge

// ===== src/pif_flags.sv
// Peripheral interrupt request flags, enables and combined request.
`timescale 1ns/1ps
`include "pif_regs.svh"
module pif_flags #(
   parameter int PORT_FLAGS = 25 // Number of per-port pin-change flag bits.
) (
   input wire logic mclk, // System clock, 25 MHz.
   input wire logic sys_rst, // Synchronous reset, active high.
   input wire logic [`PIF_ADDR_W-1:0] reg_addr, // Register address.
   input wire logic [7:0] reg_wdata, // Write data.
   input wire logic reg_wr, // Write strobe.
   input wire logic reg_rd, // Read strobe.
   output logic [7:0] reg_rdata, // Read data, one cycle after strobe.
   input wire logic ext_pin, // Routed external interrupt pin, asynchronous.
   input wire logic timer_zero_ovf, // Timer-zero overflow pulse.
   input wire logic [PORT_FLAGS-1:0] per_port_change_flags, // Port change flags.
   input wire pif_pkg::pif_capcomp_mode_type ccp1_mode, // Capcomp-one mode.
   input wire logic ccp1_capture, // Capcomp-one capture event.
   input wire logic ccp1_match, // Capcomp-one compare match.
   input wire logic ccp1_trail, // Capcomp-one PWM trailing edge.
   input wire pif_pkg::pif_capcomp_mode_type ccp2_mode, // Capcomp-two mode.
   input wire logic ccp2_capture, // Capcomp-two capture event.
   input wire logic ccp2_match, // Capcomp-two compare match.
   input wire logic ccp2_trail, // Capcomp-two PWM trailing edge.
   input wire logic timer_two_evt, // Timer-two event pulse.
   input wire logic timer_one_evt, // Timer-one event pulse.
   input wire logic rx_not_empty, // Receive buffer holds a byte.
   input wire logic tx_empty, // Transmit buffer is empty.
   input wire logic bus_collision_evt, // Bus collision pulse.
   input wire logic serial_port_evt, // Serial port event pulse.
   input wire logic converter_evt, // Conversion done pulse.
   input wire logic memory_done_evt, // Memory operation done pulse.
   input wire logic gate_active, // Timer-one gate level, same clock.
   output logic irq_req // Combined interrupt request.
);
   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed {
      logic [7:0] req0; // First request register, sticky bits only.
      logic [7:0] req1; // Second request register, sticky bits only.
      logic [7:0] req2; // Third request register.
      logic [7:0] first_level_enables; // First-level enables.
      logic [7:0] second_level_enables_a; // Second-level enables, group a.
      logic [7:0] second_level_enables_b; // Second-level enables, group b.
      logic [7:0] global_irq_control; // Global control bits.
      logic gate_prev; // Gate level one cycle ago.
      logic [7:0] rdata; // Read data register.
      logic irq; // Combined request register.
   } pif_state_type;
   pif_state_type st_q; // Registered state.
   pif_state_type st_d; // Next state.

   logic ext_sync; // Synchronised external pin.
   logic ext_hit; // Valid edge on the external pin.
   logic [7:0] view0; // First request register as read.
   logic [7:0] view1; // Second request register as read.
   logic [7:0] set0; // Hardware set terms, first register.
   logic [7:0] set1; // Hardware set terms, second register.
   logic [7:0] set2; // Hardware set terms, third register.
   logic ccp1_hit; // Capcomp-one event in its mode.
   logic ccp2_hit; // Capcomp-two event in its mode.
   logic [7:0] wr0; // Write value to first request register.
   logic [7:0] wr1; // Write value to second request register.
   logic [7:0] wr2; // Write value to third request register.

   // ***************************************************************
   // Pin input path
   // ***************************************************************
   // The pin is asynchronous, so it passes two flops first.
   pif_sync #(.WIDTH(1)) u_sync (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .din(ext_pin),
      .dout(ext_sync)
   );

   // Edge direction follows the edge-select bit of the global control.
   pif_edge u_edge (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .level(ext_sync),
      .rising(st_q.global_irq_control[`PIF_GC_EDGE]),
      .hit(ext_hit)
   );

   // ***************************************************************
   // Event decode
   // ***************************************************************
   // Pick the capcomp event that matters in each unit's mode.
   function automatic logic capcomp_event(input pif_pkg::pif_capcomp_mode_type mode,
                                          input logic cap, input logic mat, input logic trl);
      logic r;
      r = 1'b0;
      case (mode)
         pif_pkg::pif_capcomp_capture: r = cap;
         pif_pkg::pif_capcomp_compare: r = mat;
         pif_pkg::pif_capcomp_pwm: r = trl;
         default: r = 1'b0; // The spare encoding raises nothing.
      endcase
      return r;
   endfunction : capcomp_event

   assign ccp1_hit = capcomp_event(ccp1_mode, ccp1_capture, ccp1_match, ccp1_trail);
   assign ccp2_hit = capcomp_event(ccp2_mode, ccp2_capture, ccp2_match, ccp2_trail);

   // Set terms never look at any enable, so polling always works.
   always_comb begin
      set0 = 8'h00;
      set1 = 8'h00;
      set2 = 8'h00;
      set0[`PIF_B0_TMR0] = timer_zero_ovf;
      set0[`PIF_B0_EXT] = ext_hit;
      set1 = {ccp1_hit, timer_two_evt, timer_one_evt, 2'b00,
              bus_collision_evt, serial_port_evt, converter_evt};
      set2[7] = ccp2_hit;
      set2[6] = memory_done_evt;
      set2[`PIF_B2_GATE] = st_q.gate_prev & ~gate_active;
   end

   // ***************************************************************
   // Readable views
   // ***************************************************************
   // Status bits that follow a level are merged in at read time.
   always_comb begin
      view0 = st_q.req0 & `PIF_SWMASK0;
      view0[`PIF_B0_IOC] = |per_port_change_flags;
      view1 = st_q.req1 & `PIF_SWMASK1;
      view1[`PIF_B1_RX] = rx_not_empty;
      view1[`PIF_B1_TX] = tx_empty;
   end

   // Write values for the software-writable bits of each register.
   assign wr0 = (reg_wr && reg_addr == `PIF_OFS_REQ0) ? reg_wdata : st_q.req0;
   assign wr1 = (reg_wr && reg_addr == `PIF_OFS_REQ1) ? reg_wdata : st_q.req1;
   assign wr2 = (reg_wr && reg_addr == `PIF_OFS_REQ2) ? reg_wdata : st_q.req2;

   // ***************************************************************
   // Next-state logic
   // ***************************************************************
   always_comb begin
      st_d = st_q;
      st_d.gate_prev = gate_active;
      // A set in the same cycle as a clearing write wins.
      st_d.req0 = (wr0 | set0) & `PIF_SWMASK0;
      st_d.req1 = (wr1 | set1) & `PIF_SWMASK1;
      st_d.req2 = (wr2 | set2) & `PIF_SWMASK2;
      // Enable and control registers; address decode as an if chain.
      if (reg_wr) begin
         if (reg_addr == `PIF_OFS_EN0) begin
            st_d.first_level_enables = reg_wdata & `PIF_MASK0;
         end else if (reg_addr == `PIF_OFS_EN1) begin
            st_d.second_level_enables_a = reg_wdata & `PIF_MASK1;
         end else if (reg_addr == `PIF_OFS_EN2) begin
            st_d.second_level_enables_b = reg_wdata & `PIF_MASK2;
         end else if (reg_addr == `PIF_OFS_GCTL) begin
            st_d.global_irq_control = reg_wdata & `PIF_MASKGC;
         end
      end
      // Read data stands one cycle after the strobe, zero otherwise.
      st_d.rdata = 8'h00;
      if (reg_rd) begin
         if (reg_addr == `PIF_OFS_REQ0) begin
            st_d.rdata = view0;
         end else if (reg_addr == `PIF_OFS_REQ1) begin
            st_d.rdata = view1;
         end else if (reg_addr == `PIF_OFS_REQ2) begin
            st_d.rdata = st_q.req2;
         end else if (reg_addr == `PIF_OFS_EN0) begin
            st_d.rdata = st_q.first_level_enables;
         end else if (reg_addr == `PIF_OFS_EN1) begin
            st_d.rdata = st_q.second_level_enables_a;
         end else if (reg_addr == `PIF_OFS_EN2) begin
            st_d.rdata = st_q.second_level_enables_b;
         end else if (reg_addr == `PIF_OFS_GCTL) begin
            st_d.rdata = st_q.global_irq_control;
         end else begin
            st_d.rdata = 8'h00;
         end
      end
      // Combined request: first-level needs only global; others need peripheral.
      // Software should clear a stale flag before enabling it, else this fires at once.
      st_d.irq = st_q.global_irq_control[`PIF_GC_GLOBAL] &
                 ((|(view0 & st_q.first_level_enables)) |
                  (st_q.global_irq_control[`PIF_GC_PERIPH] &
                   ((|(view1 & st_q.second_level_enables_a)) |
                    (|(st_q.req2 & st_q.second_level_enables_b)))));
   end

   // Register all state; reset puts every register at its documented value.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_q.req0 <= `PIF_RST_REQ;
         st_q.req1 <= `PIF_RST_REQ;
         st_q.req2 <= `PIF_RST_REQ;
         st_q.first_level_enables <= `PIF_RST_EN;
         st_q.second_level_enables_a <= `PIF_RST_EN;
         st_q.second_level_enables_b <= `PIF_RST_EN;
         st_q.global_irq_control <= `PIF_RST_GCTL;
         st_q.gate_prev <= 1'b0;
         st_q.rdata <= 8'h00;
         st_q.irq <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   assign reg_rdata = st_q.rdata;
   assign irq_req = st_q.irq;
endmodule : pif_flags

// ===== tb/pif_flags_props.sv
// Concurrent checks on the ports of the peripheral interrupt flag block.
`timescale 1ns/1ps
`include "pif_regs.svh"
module pif_flags_chk #(
   parameter int PORT_FLAGS = 25 // Number of per-port change flags.
) (
   input wire logic mclk, // System clock.
   input wire logic sys_rst, // Synchronous reset.
   input wire logic [`PIF_ADDR_W-1:0] reg_addr, // Register address.
   input wire logic [7:0] reg_wdata, // Write data.
   input wire logic reg_wr, // Write strobe.
   input wire logic reg_rd, // Read strobe.
   input wire logic [7:0] reg_rdata, // Read data.
   input wire logic timer_zero_ovf, // Timer-zero overflow pulse.
   input wire logic [PORT_FLAGS-1:0] per_port_change_flags, // Port change flags.
   input wire logic rx_not_empty, // Receive buffer level.
   input wire logic tx_empty, // Transmit buffer level.
   input wire logic bus_collision_evt, // Bus collision pulse.
   input wire logic memory_done_evt, // Memory done pulse.
   input wire logic irq_req // Combined request.
);
   // ***************************************************************
   // Sequences
   // ***************************************************************
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // A read of each request register, used as the second step of a set check.
   sequence s_rd0; reg_rd && reg_addr == `PIF_OFS_REQ0; endsequence
   sequence s_rd1; reg_rd && reg_addr == `PIF_OFS_REQ1; endsequence
   sequence s_rd2; reg_rd && reg_addr == `PIF_OFS_REQ2; endsequence
   // A clearing write that collides with the memory event, then a quiet cycle.
   sequence s_clash;
      reg_wr && reg_addr == `PIF_OFS_REQ2 && !reg_wdata[6] && memory_done_evt ##1 !reg_wr;
   endsequence
   // ***************************************************************
   // Assertions
   // ***************************************************************
   rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   req0_unused_a: assert property (s_rd0 |=> (reg_rdata & 8'hce) == 8'h00)
      else $error("unused request bits read as one");
   ioc_live_a: assert property (s_rd0 |=> reg_rdata[4] == $past(|per_port_change_flags))
      else $error("pin change summary differs from port flags");
   rxtx_live_a: assert property (s_rd1 |=> reg_rdata[4:3] == $past({rx_not_empty, tx_empty}))
      else $error("buffer status bits differ from levels");
   tmr0_sticky_a: assert property (timer_zero_ovf ##1 s_rd0 |=> reg_rdata[5])
      else $error("timer zero flag missing after overflow");
   coll_sticky_a: assert property (bus_collision_evt ##1 s_rd1 |=> reg_rdata[2])
      else $error("collision flag missing after event");
   mem_sticky_a: assert property (memory_done_evt ##1 s_rd2 |=> reg_rdata[6])
      else $error("memory done flag missing after event");
   set_wins_a: assert property (s_clash ##1 s_rd2 |=> reg_rdata[6])
      else $error("clearing write lost a same cycle event");
   irq_off_a: assert property (reg_wr && reg_addr == `PIF_OFS_GCTL && !reg_wdata[7] |-> ##2 !irq_req)
      else $error("request stays up with global enable clear");
endmodule : pif_flags_chk
bind pif_flags pif_flags_chk #(.PORT_FLAGS(PORT_FLAGS)) u_chk (.mclk, .sys_rst, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .timer_zero_ovf, .per_port_change_flags,
   .rx_not_empty, .tx_empty, .bus_collision_evt, .memory_done_evt, .irq_req);

// ===== tb/pif_periph.sv
// Model of the peripherals that raise one-cycle event pulses.
`timescale 1ns/1ps
module pif_periph (
   input wire logic mclk, // System clock.
   input wire logic [6:0] fire, // Bench request, one bit per source.
   output logic [6:0] evt // Event pulses on the system clock.
);
   // ***************************************************************
   // Pulse logic
   // ***************************************************************
   // Registered so each pulse lands cleanly after an edge, as a real source would.
   always_ff @(posedge mclk) begin
      evt <= fire;
   end
endmodule : pif_periph

// ===== tb/pif_flags_tb.sv
// Self-checking testbench for the peripheral interrupt flag block.
`timescale 1ns/1ps
`include "pif_regs.svh"
module pif_flags_tb;
   logic mclk = 1'b0; // System clock.
   logic sys_rst = 1'b1; // Reset, held at start.
   logic [11:0] reg_addr = 12'h000; // Register address.
   logic [7:0] reg_wdata = 8'h00; // Write data.
   logic [7:0] rd_v; // Last value read.
   logic reg_wr = 1'b0; // Write strobe.
   logic reg_rd = 1'b0; // Read strobe.
   logic [7:0] reg_rdata; // Read data.
   logic ext_pin = 1'b0; // External pin.
   logic rx = 1'b0; // Receive buffer holds data.
   logic tx = 1'b0; // Transmit buffer empty.
   logic gate = 1'b0; // Timer-one gate level.
   logic irq; // Combined request.
   logic [24:0] ports = 25'h0; // Per-port change flags.
   logic [6:0] fire = 7'h00; // Event requests to the model.
   logic [6:0] evt; // Event pulses.
   logic [2:0] ev1 = 3'h0; // Capcomp-one trail, match, capture.
   logic [2:0] ev2 = 3'h0; // Capcomp-two trail, match, capture.
   pif_pkg::pif_capcomp_mode_type m1 = pif_pkg::pif_capcomp_capture; // Capcomp-one mode.
   pif_pkg::pif_capcomp_mode_type m2 = pif_pkg::pif_capcomp_capture; // Capcomp-two mode.
   int n_fail = 0; // Mismatches.
   int samples_checked = 0; // Comparisons.
   int cyc = 0; // Cycle count for the hang limit.
   logic [11:0] ea [7] = '{`PIF_OFS_REQ0, `PIF_OFS_REQ1, `PIF_OFS_REQ1, `PIF_OFS_REQ1,
      `PIF_OFS_REQ1, `PIF_OFS_REQ1, `PIF_OFS_REQ2}; // Register of each event.
   int eb [7] = '{5, 6, 5, 2, 1, 0, 6}; // Bit of each event.
   pif_periph u_per (.mclk, .fire, .evt);
   pif_flags #(.PORT_FLAGS(25)) u_dut (.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .ext_pin, .timer_zero_ovf(evt[0]), .per_port_change_flags(ports),
      .ccp1_mode(m1), .ccp1_capture(ev1[0]), .ccp1_match(ev1[1]), .ccp1_trail(ev1[2]),
      .ccp2_mode(m2), .ccp2_capture(ev2[0]), .ccp2_match(ev2[1]), .ccp2_trail(ev2[2]),
      .timer_two_evt(evt[1]), .timer_one_evt(evt[2]), .rx_not_empty(rx), .tx_empty(tx),
      .bus_collision_evt(evt[3]), .serial_port_evt(evt[4]), .converter_evt(evt[5]),
      .memory_done_evt(evt[6]), .gate_active(gate), .irq_req(irq));
   // ***************************************************************
   // Clock, hang limit and tasks
   // ***************************************************************
   // Free-running 25 MHz clock.
   always #20 mclk = ~mclk;
   // The whole run needs well under a thousand cycles.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         end_sim();
      end
   end
   task end_sim;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim
   // Count one comparison and report a mismatch; the case inequality lets no unknown pass.
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe, so sample just past that edge.
   task rc(input logic [11:0] a, input logic [7:0] exp);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 rd_v = reg_rdata;
      chk(rd_v, exp);
      // End on an edge, so that whatever the caller drives next changes on a rising edge.
      @(posedge mclk);
   endtask : rc
   task pulse(input int i);
      @(posedge mclk);
      fire <= 7'h01 << i;
      @(posedge mclk);
      fire <= 7'h00;
   endtask : pulse
   task ci(input logic e);
      repeat (3) @(posedge mclk);
      #1 chk({7'h00, irq}, {7'h00, e});
      // Same reason as in the read task: the next stimulus lands on an edge.
      @(posedge mclk);
   endtask : ci
   task tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick
   // ***************************************************************
   // Tests
   // ***************************************************************
   initial begin
      tick(8);
      sys_rst <= 1'b0;
      rc(`PIF_OFS_REQ0, 8'h00);
      rc(`PIF_OFS_REQ1, 8'h00);
      rc(`PIF_OFS_REQ2, 8'h00);
      rc(`PIF_OFS_GCTL, 8'h01);
      rc(12'h123, 8'h00);
      $display("test reset done");
      // Every pulsed event source of the model, with all enables still clear.
      for (int i = 0; i < 7; i++) begin
         pulse(i);
         rc(ea[i], 8'h01 << eb[i]);
         wr(ea[i], 8'h00);
         rc(ea[i], 8'h00);
      end
      $display("test events done");
      // Only the event that matches the mode may set a capcomp flag.
      for (int u = 1; u < 3; u++) begin
         for (int m = 0; m < 3; m++) begin
            m1 <= pif_pkg::pif_capcomp_mode_type'(m);
            m2 <= pif_pkg::pif_capcomp_mode_type'(m);
            for (int e = 0; e < 3; e++) begin
               @(posedge mclk);
               if (u == 1) begin
                  ev1 <= 3'h1 << e;
               end else begin
                  ev2 <= 3'h1 << e;
               end
               @(posedge mclk);
               ev1 <= 3'h0;
               ev2 <= 3'h0;
               rc(u == 1 ? `PIF_OFS_REQ1 : `PIF_OFS_REQ2, e == m ? 8'h80 : 8'h00);
               wr(u == 1 ? `PIF_OFS_REQ1 : `PIF_OFS_REQ2, 8'h00);
            end
         end
      end
      $display("test capcomp done");
      // Read-only live bits ignore a clearing write.
      ports <= 25'h1000000;
      rx <= 1'b1;
      tx <= 1'b1;
      wr(`PIF_OFS_REQ0, 8'h00);
      wr(`PIF_OFS_REQ1, 8'h00);
      rc(`PIF_OFS_REQ0, 8'h10);
      rc(`PIF_OFS_REQ1, 8'h18);
      ports <= 25'h0;
      rx <= 1'b0;
      tx <= 1'b0;
      rc(`PIF_OFS_REQ0, 8'h00);
      rc(`PIF_OFS_REQ1, 8'h00);
      $display("test live bits done");
      // External pin: rising by default, then falling only.
      ext_pin <= 1'b1;
      tick(5);
      rc(`PIF_OFS_REQ0, 8'h01);
      wr(`PIF_OFS_GCTL, 8'h00);
      wr(`PIF_OFS_REQ0, 8'h00);
      ext_pin <= 1'b0;
      tick(5);
      rc(`PIF_OFS_REQ0, 8'h01);
      wr(`PIF_OFS_REQ0, 8'h00);
      ext_pin <= 1'b1;
      tick(5);
      rc(`PIF_OFS_REQ0, 8'h00);
      gate <= 1'b0;
      tick(2);
      gate <= 1'b1;
      tick(3);
      rc(`PIF_OFS_REQ2, 8'h00);
      gate <= 1'b0;
      rc(`PIF_OFS_REQ2, 8'h20);
      // A clearing write in the very cycle of a memory event must not lose it.
      @(posedge mclk);
      fire <= 7'h40;
      @(posedge mclk);
      fire <= 7'h00;
      reg_wr <= 1'b1;
      reg_addr <= `PIF_OFS_REQ2;
      reg_wdata <= 8'h00;
      @(posedge mclk);
      reg_wr <= 1'b0;
      rc(`PIF_OFS_REQ2, 8'h40);
      $display("test pins done");
      // Combined request and its gating.
      wr(`PIF_OFS_REQ2, 8'h00);
      wr(`PIF_OFS_EN0, 8'h20);
      wr(`PIF_OFS_GCTL, 8'h80);
      pulse(0);
      ci(1'b1);
      wr(`PIF_OFS_GCTL, 8'h00);
      ci(1'b0);
      wr(`PIF_OFS_REQ0, 8'h00);
      wr(`PIF_OFS_EN0, 8'h00);
      wr(`PIF_OFS_EN1, 8'h40);
      wr(`PIF_OFS_GCTL, 8'h80);
      pulse(1);
      ci(1'b0);
      wr(`PIF_OFS_GCTL, 8'hc0);
      ci(1'b1);
      wr(`PIF_OFS_REQ1, 8'h00);
      wr(`PIF_OFS_EN1, 8'h00);
      wr(`PIF_OFS_EN2, 8'h20);
      ci(1'b0);
      gate <= 1'b1;
      tick(2);
      gate <= 1'b0;
      ci(1'b1);
      $display("test request done");
      end_sim();
   end
endmodule : pif_flags_tb
